// *** src/dcg_gate.sv ***
// Debug command decoder and gate with status register and runtime counter.
//
// Behaviour
// - Every operation arrives as a decoded command byte.
// - Outside debug mode only 00,02,04,05 execute.
// - Debug mode accepts 00 and 02 to 0d, except protection restrictions.
// - Command 02 returns status in any mode.
// - Command 04 writes control; protection keeps debug.
// - Command 05 returns control in any mode.
// - Command 03 returns counter, debug mode only.
// - PC write/read refused outside debug, protected.
// - Protected register write: flash regs, mass erase.
// - Register read, program memory refused when protected.
// - Data write blocked by protection; read allowed.
// - Read-only status register, zero at reset.
// - Bit7 debug mode, bit6 processor halted.
// - Bit5 low while protection in force.
// - Status bits four to zero read zero.
// - 16-bit counter runs outside debug, saturates.
`timescale 1ns/1ps
module dcg_gate
   import dcg_pkg::*;
#(
   parameter logic [15:0] REV_ID         = REV_DEFAULT,
   parameter logic [15:0] FLASH_REG_LO   = 16'h0ff8,
   parameter logic [15:0] FLASH_REG_HI   = 16'h0fff,
   parameter logic [15:0] FLASH_CMD_REG  = 16'h0ff8,
   parameter logic [7:0]  MASS_ERASE_VAL = 8'h63
)(
   // Clock and reset.
   input  wire logic         clk_sys_in,
   input  wire logic         rst_in,
   // Command from the debug serial pin deserialiser.
   input  wire logic         cmd_valid_in,
   input  wire logic [7:0]   cmd_code_in,
   input  wire logic [15:0]  cmd_addr_in,
   input  wire logic [7:0]   cmd_data_in,
   // System state.
   input  wire logic         read_protect_option_in,
   input  wire logic         cpu_halted_in,
   // Accepted command toward the core.
   output logic              exec_valid_out,
   output dcg_cmd_s          exec_cmd_out,
   output logic [7:0]        exec_data_out,
   output logic              refused_out,
   // Read reply toward the host.
   output logic              reply_valid_out,
   output logic [15:0]       reply_data_out,
   // Mode outputs.
   output logic              debug_mode_ctl_out,
   output logic [7:0]        debug_state_flags_out,
   output logic [RTC_W-1:0]  runtime_count_out
);

   ////////////////////////////////////////////////////////////////////////
   // State.
   logic [7:0]  ctl_ff, nxt_ctl;
   logic        exec_valid_ff, nxt_exec_valid;
   dcg_cmd_s    exec_cmd_ff, nxt_exec_cmd;
   logic [7:0]  exec_data_ff, nxt_exec_data;
   logic        refused_ff, nxt_refused;
   logic        reply_valid_ff, nxt_reply_valid;
   logic [15:0] reply_ff, nxt_reply;
   logic [2:0]  prot_sync_ff;
   logic        prot_ff, nxt_prot;
   logic [2:0]  halt_sync_ff;
   logic        halt_ff, nxt_halt;

   logic        dbg;
   logic        prot;
   logic [7:0]  stat;
   logic [RTC_W-1:0] rtc;
   logic        allow;
   logic        is_read;
   logic        flash_ok;

   assign dbg  = ctl_ff[CTL_DEBUG_MODE_CTL_BIT];
   assign prot = prot_ff;

   // Status view built from live state.
   always_comb
   begin
      stat                  = STAT_RESET;
      stat[STAT_DBG_BIT]    = dbg;
      stat[STAT_HALT_BIT]   = halt_ff;
      stat[STAT_NOPROT_BIT] = ~prot;
   end

   ////////////////////////////////////////////////////////////////////////
   // Runtime counter: runs outside debug mode, cleared on leaving it.
   dcg_rtc #(
      .W          (RTC_W)
   ) u_rtc (
      .clk_sys_in (clk_sys_in),
      .rst_in     (rst_in),
      .run_in     (~dbg),
      .clear_in   (dbg && !nxt_ctl[CTL_DEBUG_MODE_CTL_BIT]),
      .count_out  (rtc)
   );

   // Permission check for one command byte.
   always_comb
   begin
      flash_ok = (cmd_addr_in >= FLASH_REG_LO)
              && (cmd_addr_in <= FLASH_REG_HI)
              && ((cmd_addr_in != FLASH_CMD_REG)
                  || (cmd_data_in == MASS_ERASE_VAL));
      allow   = 1'b0;
      is_read = 1'b0;
      unique case (cmd_code_in)
         CMD_READ_REV, CMD_READ_STAT, CMD_READ_CTL:
         begin
            allow   = 1'b1;
            is_read = 1'b1;
         end
         CMD_WRITE_CTL:  allow = 1'b1;
         CMD_READ_RTC:
         begin
            allow   = dbg;
            is_read = 1'b1;
         end
         CMD_WRITE_PC, CMD_READ_PC:
            allow = dbg && !prot;
         CMD_WRITE_REG:  allow = dbg && (!prot || flash_ok);
         CMD_READ_REG, CMD_WRITE_PMEM, CMD_READ_PMEM:
            allow = dbg && !prot;
         CMD_WRITE_DMEM: allow = dbg && !prot;
         CMD_READ_DMEM:  allow = dbg;
         default:        allow = 1'b0;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////
   // Next values for control, replies and forwarded commands.
   always_comb
   begin
      nxt_ctl         = ctl_ff;
      nxt_exec_valid  = 1'b0;
      nxt_exec_cmd    = exec_cmd_ff;
      nxt_exec_data   = exec_data_ff;
      nxt_refused     = 1'b0;
      nxt_reply_valid = 1'b0;
      nxt_reply       = reply_ff;
      if (cmd_valid_in)
      begin
         if (!allow)
         begin
            nxt_refused = (cmd_code_in <= CMD_READ_DMEM)
                       && (cmd_code_in != CMD_RESERVED);
         end
         else if (is_read)
         begin
            nxt_reply_valid = 1'b1;
            unique case (cmd_code_in)
               CMD_READ_REV:  nxt_reply = REV_ID;
               CMD_READ_STAT: nxt_reply = {8'h00, stat};
               CMD_READ_CTL:  nxt_reply = {8'h00, ctl_ff};
               default:       nxt_reply = rtc;
            endcase
         end
         else if (cmd_code_in == CMD_WRITE_CTL)
         begin
            nxt_ctl = cmd_data_in;
            if (prot && dbg)
            begin
               nxt_ctl[CTL_DEBUG_MODE_CTL_BIT] = 1'b1;
            end
         end
         else
         begin
            nxt_exec_valid    = 1'b1;
            nxt_exec_cmd.code = cmd_code_in;
            nxt_exec_cmd.arg  = cmd_addr_in;
            nxt_exec_data     = cmd_data_in;
         end
      end
   end

   // Three-stage synchronisers; change counts when stages 2 and 3 agree.
   always_comb
   begin
      nxt_prot = (prot_sync_ff[1] == prot_sync_ff[2])
               ? prot_sync_ff[2] : prot_ff;
      nxt_halt = (halt_sync_ff[1] == halt_sync_ff[2])
               ? halt_sync_ff[2] : halt_ff;
   end

   // Register stage.
   always_ff @(posedge clk_sys_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         ctl_ff         <= CTL_RESET;
         exec_valid_ff  <= 1'b0;
         exec_cmd_ff    <= '0;
         exec_data_ff   <= 8'h00;
         refused_ff     <= 1'b0;
         reply_valid_ff <= 1'b0;
         reply_ff       <= 16'h0000;
         // Protection counts as in force until the pin is seen low.
         prot_sync_ff   <= 3'h7;
         prot_ff        <= 1'b1;
         halt_sync_ff   <= 3'h0;
         halt_ff        <= 1'b0;
      end
      else
      begin
         ctl_ff         <= nxt_ctl;
         exec_valid_ff  <= nxt_exec_valid;
         exec_cmd_ff    <= nxt_exec_cmd;
         exec_data_ff   <= nxt_exec_data;
         refused_ff     <= nxt_refused;
         reply_valid_ff <= nxt_reply_valid;
         reply_ff       <= nxt_reply;
         prot_sync_ff   <= {prot_sync_ff[1:0], read_protect_option_in};
         prot_ff        <= nxt_prot;
         halt_sync_ff   <= {halt_sync_ff[1:0], cpu_halted_in};
         halt_ff        <= nxt_halt;
      end
   end

   // Outputs.
   assign exec_valid_out        = exec_valid_ff;
   assign exec_cmd_out          = exec_cmd_ff;
   assign exec_data_out         = exec_data_ff;
   assign refused_out           = refused_ff;
   assign reply_valid_out       = reply_valid_ff;
   assign reply_data_out        = reply_ff;
   assign debug_mode_ctl_out    = dbg;
   assign debug_state_flags_out = stat;
   assign runtime_count_out     = rtc;

endmodule // dcg_gate

// *** src/dcg_pkg.sv ***
// Package of constants and types for the debug command gate.
package dcg_pkg;

   // Command byte codes.
   localparam logic [7:0] CMD_READ_REV   = 8'h00;
   localparam logic [7:0] CMD_RESERVED   = 8'h01;
   localparam logic [7:0] CMD_READ_STAT  = 8'h02;
   localparam logic [7:0] CMD_READ_RTC   = 8'h03;
   localparam logic [7:0] CMD_WRITE_CTL  = 8'h04;
   localparam logic [7:0] CMD_READ_CTL   = 8'h05;
   localparam logic [7:0] CMD_WRITE_PC   = 8'h06;
   localparam logic [7:0] CMD_READ_PC    = 8'h07;
   localparam logic [7:0] CMD_WRITE_REG  = 8'h08;
   localparam logic [7:0] CMD_READ_REG   = 8'h09;
   localparam logic [7:0] CMD_WRITE_PMEM = 8'h0a;
   localparam logic [7:0] CMD_READ_PMEM  = 8'h0b;
   localparam logic [7:0] CMD_WRITE_DMEM = 8'h0c;
   localparam logic [7:0] CMD_READ_DMEM  = 8'h0d;

   // Status register field positions and reset value.
   localparam int         STAT_DBG_BIT    = 7;
   localparam int         STAT_HALT_BIT   = 6;
   localparam int         STAT_NOPROT_BIT = 5;
   localparam logic [7:0] STAT_RESET      = 8'h00;

   // Control register: debug mode control bit position and reset.
   localparam int         CTL_DEBUG_MODE_CTL_BIT = 7;
   localparam logic [7:0] CTL_RESET       = 8'h00;

   // Runtime counter width, reset and ceiling.
   localparam int          RTC_W     = 16;
   localparam logic [15:0] RTC_RESET = 16'h0000;
   localparam logic [15:0] RTC_MAX   = 16'hffff;

   // Reply to a read revision command; value is arbitrary.
   localparam logic [15:0] REV_DEFAULT = 16'h0100;

   // A decoded command as it leaves the gate.
   typedef struct packed {
      logic [7:0]  code;
      logic [15:0] arg;
   } dcg_cmd_s;

endpackage : dcg_pkg

// *** src/dcg_rtc.sv ***
// Saturating runtime counter of system clock cycles.
`timescale 1ns/1ps
module dcg_rtc
   import dcg_pkg::*;
#(
   parameter int W = RTC_W
)(
   // Clock and reset.
   input  wire logic         clk_sys_in,
   input  wire logic         rst_in,
   // Control.
   input  wire logic         run_in,
   input  wire logic         clear_in,
   // Count.
   output logic [W-1:0]      count_out
);

   logic [W-1:0] count_ff;
   logic [W-1:0] nxt_count;

   // Counts while running, restarts on clear, stops at all ones.
   always_comb
   begin
      nxt_count = count_ff;
      if (clear_in)
      begin
         nxt_count = '0;
      end
      else if (run_in && (count_ff != {W{1'b1}}))
      begin
         nxt_count = count_ff + 1'b1;
      end
   end

   // Register stage.
   always_ff @(posedge clk_sys_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         count_ff <= '0;
      end
      else
      begin
         count_ff <= nxt_count;
      end
   end

   assign count_out = count_ff;

endmodule // dcg_rtc

// *** testbench/dcg_gate_checker.sv ***
// Port assertions for the debug command gate.
`timescale 1ns/1ps
module dcg_gate_checker
   import dcg_pkg::*;
(
   // Clock and reset.
   input wire logic             clk_sys_in,
   input wire logic             rst_in,
   // Watched ports.
   input wire logic             cmd_valid_in,
   input wire logic [7:0]       cmd_code_in,
   input wire logic             exec_valid_out,
   input wire logic             refused_out,
   input wire logic             reply_valid_out,
   input wire logic             debug_mode_ctl_out,
   input wire logic [7:0]       debug_state_flags_out,
   input wire logic [RTC_W-1:0] runtime_count_out
);
   // All checks run on the system clock and rest during reset.
   default clocking cb @(posedge clk_sys_in); endclocking
   default disable iff (rst_in);

   chk_stat_reply:
   assert property (cmd_valid_in && cmd_code_in == CMD_READ_STAT
      |=> reply_valid_out) else $error("Status read gave no reply.");
   chk_normal_refuse:
   assert property (cmd_valid_in && !debug_mode_ctl_out &&
      cmd_code_in inside {8'h03, [8'h06:8'h0d]} |=> refused_out &&
      !exec_valid_out) else $error("Command ran outside debug mode.");
   chk_undef_quiet:
   assert property (cmd_valid_in && (cmd_code_in == 8'h01 ||
      cmd_code_in > 8'h0d) |=> !(reply_valid_out || exec_valid_out ||
      refused_out)) else $error("Undefined command had an effect.");
   chk_prot_pc:
   assert property (cmd_valid_in && !debug_state_flags_out[5] &&
      cmd_code_in inside {8'h06, 8'h07} |=> refused_out)
      else $error("Protected counter access not refused.");
   chk_stat_resv:
   assert property (debug_state_flags_out[4:0] == 5'h00)
      else $error("Reserved status bits not zero.");
   chk_rtc_run:
   assert property (!rst_in && !debug_mode_ctl_out &&
      runtime_count_out != 16'hffff ##1 !debug_mode_ctl_out |->
      runtime_count_out == $past(runtime_count_out) + 16'h0001)
      else $error("Counter stalled.");
   chk_rtc_hold:
   assert property (debug_mode_ctl_out ##1 debug_mode_ctl_out
      |-> $stable(runtime_count_out)) else $error("Counter ran in debug.");
   chk_dbg_kept:
   assert property (cmd_valid_in && cmd_code_in == CMD_WRITE_CTL &&
      debug_mode_ctl_out && !debug_state_flags_out[5] |=>
      debug_mode_ctl_out) else $error("Protected write left debug mode.");
endmodule // dcg_gate_checker

bind dcg_gate dcg_gate_checker u_chk (.clk_sys_in, .rst_in, .cmd_valid_in,
   .cmd_code_in, .exec_valid_out, .refused_out, .reply_valid_out,
   .debug_mode_ctl_out, .debug_state_flags_out, .runtime_count_out);

// *** testbench/dcg_host.sv ***
// Host debugger model that sends command bytes into the gate.
`timescale 1ns/1ps
module dcg_host
(
   // Clock.
   input  wire logic  clk_sys_in,
   // Command toward the gate.
   output logic       cmd_valid_out,
   output logic [7:0] cmd_code_out,
   output logic [15:0] cmd_addr_out,
   output logic [7:0] cmd_data_out
);
   // Bus starts idle.
   initial
   begin
      cmd_valid_out = 1'b0;
      cmd_code_out = 8'h00;
      cmd_addr_out = 16'h0000;
      cmd_data_out = 8'h00;
   end

   // One command byte for one cycle; released fields show inverted data.
   task automatic send(input logic [7:0] c, input logic [15:0] a,
                       input logic [7:0] d);
      @(posedge clk_sys_in);
      cmd_valid_out <= 1'b1;
      cmd_code_out <= c;
      cmd_addr_out <= a;
      cmd_data_out <= d;
      @(posedge clk_sys_in);
      cmd_valid_out <= 1'b0;
      cmd_code_out <= ~c;
      cmd_addr_out <= ~a;
      cmd_data_out <= ~d;
   endtask
endmodule // dcg_host

// *** testbench/tb.sv ***
// Self-checking testbench for the debug command gate.
`timescale 1ns/1ps
module tb;
   import dcg_pkg::*;
   logic        clk_sys_in, rst_in, prot, halt, cv, ev, rf, rv, dm;
   logic [7:0]  cc, cd, ed, fl;
   logic [15:0] ca, rd, rc, a, rt, cyc;
   dcg_cmd_s    ec;
   logic [34:0] q[$];
   logic [34:0] e, s;
   int          mismatches, checked, seed, i;

   dcg_host host (.clk_sys_in(clk_sys_in), .cmd_valid_out(cv),
      .cmd_code_out(cc), .cmd_addr_out(ca), .cmd_data_out(cd));
   dcg_gate dut (.clk_sys_in(clk_sys_in), .rst_in(rst_in),
      .cmd_valid_in(cv), .cmd_code_in(cc), .cmd_addr_in(ca),
      .cmd_data_in(cd), .read_protect_option_in(prot),
      .cpu_halted_in(halt), .exec_valid_out(ev), .exec_cmd_out(ec),
      .exec_data_out(ed), .refused_out(rf), .reply_valid_out(rv),
      .reply_data_out(rd), .debug_mode_ctl_out(dm),
      .debug_state_flags_out(fl), .runtime_count_out(rc));

   // Clock at 200 MHz.
   initial
   begin
      clk_sys_in = 1'b0;
      forever #2.5 clk_sys_in = ~clk_sys_in;
   end

   // Notes the expected result (0 reply, 1 exec with code and data,
   // 2 refused, 4 nothing) and sends the command.
   task automatic cmd(input logic [7:0] c, input logic [15:0] ad,
                      input logic [7:0] d, input logic [2:0] k,
                      input logic [15:0] v);
      if (k != 3'd4)
         q.push_back({k, (k == 3'd1) ? {c, d} : 16'h0000, v});
      host.send(c, ad, d);
   endtask

   // Prints counts and the verdict, then stops.
   task end_sim;
      $display("checked=%0d mismatches=%0d", checked, mismatches);
      if (mismatches == 0 && checked > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   // Compares each pulse with the oldest note, between clock edges.
   always @(negedge clk_sys_in)
      if (!rst_in && (rv || ev || rf))
      begin
         s = rv ? {3'd0, 16'h0000, rd} : ev ? {3'd1, ec.code, ed, ec.arg}
             : {3'd2, 32'h0000_0000};
         e = (q.size() > 0) ? q.pop_front() : 35'h7_ffff_ffff;
         checked++;
         if (e !== s)
         begin
            mismatches++;
            $display("[FAIL] result exp=%h seen=%h", e, s);
         end
      end

   // Reference for the runtime counter: edges since reset release.
   always @(posedge clk_sys_in)
      if (!rst_in)
         cyc <= cyc + 16'h0001;

   // Cuts a hang short.
   initial
   begin
      repeat (3000) @(posedge clk_sys_in);
      mismatches++;
      $display("[FAIL] run timeout exp=done seen=hang");
      end_sim;
   end

   // Main sequence.
   initial
   begin
      seed = 32'h02aeec52;
      rst_in = 1'b1;
      prot = 1'b0;
      halt = 1'b0;
      mismatches = 0;
      checked = 0;
      cyc = 16'h0000;
      repeat (4) @(posedge clk_sys_in);
      checked++;
      if (fl !== STAT_RESET)
      begin
         mismatches++;
         $display("[FAIL] status in reset exp=%h seen=%h", STAT_RESET, fl);
      end
      rst_in <= 1'b0;
      // Lets the protection synchroniser settle after release.
      repeat (6) @(posedge clk_sys_in);
      cmd(CMD_READ_STAT, 0, 0, 0, 16'h0020);
      // Code 04 stores 63 in control with the debug bit clear; 05 reads it.
      for (i = 0; i < 16; i++)
         cmd(i[7:0], 16'h0ff8, 8'h63, (i == 0 || i == 2 || i == 5) ? 3'd0 :
            (i == 1 || i == 4 || i > 13) ? 3'd4 : 3'd2, (i == 0) ?
            REV_DEFAULT : (i == 2) ? 16'h0020 : (i == 5) ? 16'h0063 :
            16'h0000);
      cmd(CMD_WRITE_CTL, 0, 8'h80, 4, 0);
      // The counter froze at the edge that took the write; keep its value.
      @(negedge clk_sys_in);
      rt = cyc;
      cmd(CMD_READ_CTL, 0, 0, 0, 16'h0080);
      for (i = 6; i < 14; i++)
      begin
         a = $random(seed);
         cmd(i[7:0], a, $random(seed), 1, a);
      end
      cmd(CMD_READ_RTC, 0, 0, 0, rt);
      prot <= 1'b1;
      halt <= 1'b1;
      repeat (6) @(posedge clk_sys_in);
      cmd(CMD_READ_STAT, 0, 0, 0, 16'h00c0);
      for (i = 6; i < 14; i++)
         cmd(i[7:0], 16'h0100, 8'h63, (i == 13) ? 3'd1 : 3'd2,
            (i == 13) ? 16'h0100 : 16'h0000);
      cmd(CMD_WRITE_REG, 16'h0ff8, 8'h63, 1, 16'h0ff8);
      cmd(CMD_WRITE_REG, 16'h0ff8, 8'h00, 2, 0);
      cmd(CMD_WRITE_REG, 16'h0ffa, 8'h55, 1, 16'h0ffa);
      cmd(CMD_READ_RTC, 0, 0, 0, rt);
      cmd(CMD_WRITE_CTL, 0, 8'h00, 4, 0);
      cmd(CMD_READ_CTL, 0, 0, 0, 16'h0080);
      prot <= 1'b0;
      halt <= 1'b0;
      repeat (6) @(posedge clk_sys_in);
      cmd(CMD_WRITE_CTL, 0, 8'h00, 4, 0);
      cmd(CMD_READ_STAT, 0, 0, 0, 16'h0020);
      repeat (40) @(posedge clk_sys_in);
      for (i = 0; i < 10 && q.size() > 0; i++)
         @(posedge clk_sys_in);
      checked++;
      if (q.size() != 0)
      begin
         mismatches++;
         $display("[FAIL] pending exp=0 seen=%0d", q.size());
      end
      end_sim;
   end
endmodule // tb
